//--- rtl/gpio_wake_defs.svh
/*
  Register offsets, field positions, reset values, pin maps and timing counts of the
  general purpose pin block with wake and grouped interrupt status.
  Assumes it is included by its bare name and holds definitions only.
*/
`ifndef GPIO_WAKE_DEFS_SVH
`define GPIO_WAKE_DEFS_SVH

// per-pin configuration byte
`define CFG_DIR_BIT       0
`define CFG_POL_BIT       1
`define CFG_FUNC_LSB      2
`define CFG_FUNC_MSB      3
`define CFG_OD_BIT        7
`define CFG_RESET         8'h01
`define CFG_RESET_IRQPIN  8'h81
`define REG_RESET         8'h00

// pin index 15..0 in every packed map below
`define PIN_IRQ_OUT       2
`define CFG_OFFS {8'h48, 8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, \
                  8'h40, 8'h3F, 8'h3D, 8'h36, 8'h35, 8'h32, 8'h2D, 8'h2C}

`define OFF_DATA2         8'h4C
`define OFF_DATA3         8'h4D
`define OFF_DATA4         8'h4E
`define OFF_DATA5         8'h4F
`define OFF_DATA6         8'h50
`define DATA_OFFS {`OFF_DATA6, `OFF_DATA6, `OFF_DATA5, `OFF_DATA5, `OFF_DATA5, \
                   `OFF_DATA5, `OFF_DATA5, `OFF_DATA5, `OFF_DATA5, `OFF_DATA5, \
                   `OFF_DATA4, `OFF_DATA3, `OFF_DATA3, `OFF_DATA2, `OFF_DATA2, `OFF_DATA2}
`define DATA_BITS {3'h1, 3'h0, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, \
                   3'h1, 3'h0, 3'h2, 3'h3, 3'h2, 3'h7, 3'h2, 3'h1}

`define WAKE_MASK         16'hFFDF
`define IRQ_MASK          16'hFC3B
`define ALT_MASK          16'hC024
`define DUAL_EDGE_MASK    16'hC003

`define OFF_LED_ONE       8'h5D
`define OFF_LED_TWO       8'h5E
`define OFF_WAKE_PIN_STS  8'h10
`define OFF_WAKE_PIN_EN   8'h11
`define OFF_WAKE_STS1     8'h12
`define OFF_WAKE_STS3     8'h13
`define OFF_WAKE_STS5     8'h14
`define OFF_WAKE_STS6     8'h15
`define OFF_WAKE_EN1      8'h16
`define OFF_WAKE_EN3      8'h17
`define OFF_WAKE_EN5      8'h18
`define OFF_WAKE_EN6      8'h19
`define OFF_IRQ_STS1      8'h1A
`define OFF_IRQ_STS2      8'h1B
`define OFF_IRQ_STS3      8'h1C
`define OFF_IRQ_STS4      8'h1D
`define OFF_IRQ_EN1       8'h1E
`define OFF_IRQ_EN2       8'h1F
`define OFF_IRQ_EN3       8'h20
`define OFF_IRQ_EN4       8'h21
`define OFF_MISC_STS      8'h22

`define IRQEN2_PIN_BIT    7
`define IRQEN2_SERIAL_BIT 6
`define IRQEN2_WAKE_BIT   5
`define IRQEN2_IR_BIT     0
`define DEV_WAKE_BIT      5

// log2 of slow clock rises per half blink period
`define BLINK_HALF_BITS   14

`endif

//--- rtl/gpio_wake_pkg.sv
/*
  Types shared by the gpio wake block: pin function select, led mode, byte and pin vector.
  Assumes nothing of its surroundings.
*/
package gpio_wake_pkg;
  typedef enum logic [1:0] {
    FUNC_GPIO = 2'h0,
    FUNC_ALT  = 2'h1,
    FUNC_DUAL = 2'h2,
    FUNC_RSVD = 2'h3
  } func_sel_t;

  typedef enum logic [1:0] {
    LED_OFF     = 2'h0,
    LED_ON      = 2'h1,
    LED_BLINK   = 2'h2,
    LED_OFF_ALT = 2'h3
  } led_mode_t;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] pin_vec_t;
endpackage : gpio_wake_pkg

//--- rtl/pin_edge_if.sv
/*
  Synchronised pin levels with their one-cycle rise and fall strobes.
  Assumes one clock domain on both ends.
*/
`timescale 1ns/1ns
interface pin_edge_if #(
  parameter int WIDTH = 16
);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;
  modport source (output level, output rise, output fall);
  modport sink   (input level, input rise, input fall);
endinterface : pin_edge_if

//--- rtl/pin_edge_sync.sv
/*
  Two-flop synchroniser and edge detector for a vector of pins.
  Assumes pin inputs may change at any time and reset is synchronous, active high.
*/
`timescale 1ns/1ns
module pin_edge_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] rawIn,
  pin_edge_if.source            edges
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;
  logic [1:0]       fill;
  logic             primed;

  // edges stay quiet until the pipe holds real samples, so a pin high at reset is no event
  assign primed = (fill == 2'h3);

  always_ff @(posedge mclk) begin
    if (reset) begin
      meta   <= '0;
      stable <= '0;
      prev   <= '0;
      fill   <= 2'h0;
    end else begin
      meta   <= rawIn;
      stable <= meta;
      prev   <= stable;
      fill   <= primed ? fill : fill + 2'h1;
    end
  end

  assign edges.level = stable;
  assign edges.rise  = primed ? (stable & ~prev) : '0;
  assign edges.fall  = primed ? (~stable & prev) : '0;
endmodule : pin_edge_sync

//--- rtl/gpio_wake_smi_event_logic.sv
/*
  Sixteen general purpose pins with wake, grouped interrupt and led control, plus the
  runtime register file that host software reaches by address, write and read strobes.
  Assumes a synchronous host port in the mclk domain and that peripheral sources clear
  their own interrupt levels.
*/
`timescale 1ns/1ns
`include "gpio_wake_defs.svh"
module gpio_wake_smi_event_logic #(
  parameter int BLINK_HALF_BITS = `BLINK_HALF_BITS
) (
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic [7:0]              hostAddr,
  input  wire logic                    hostWr,
  input  wire logic                    hostRd,
  input  wire gpio_wake_pkg::byte_t    hostWdata,
  output gpio_wake_pkg::byte_t         hostRdata,
  input  wire gpio_wake_pkg::pin_vec_t pinIn,
  output gpio_wake_pkg::pin_vec_t      pinOut,
  output gpio_wake_pkg::pin_vec_t      pinOe,
  input  wire logic                    clk32k,
  input  wire gpio_wake_pkg::byte_t    periphIrq,
  input  wire logic                    irEvent,
  output logic                         groupIrqInternal,
  output logic                         serialIrqTwo,
  output logic                         wakeRequest
);
  import gpio_wake_pkg::*;

  localparam pin_vec_t WAKE_PINS = `WAKE_MASK;
  localparam pin_vec_t IRQ_PINS  = `IRQ_MASK;
  localparam pin_vec_t ALT_PINS  = `ALT_MASK;
  localparam pin_vec_t DUAL_PINS = `DUAL_EDGE_MASK;

  function automatic logic data_hit(input logic [7:0] addr, input int idx);
    logic [127:0] offs;
    offs = `DATA_OFFS;
    return addr == offs[idx*8 +: 8];
  endfunction : data_hit

  function automatic logic [2:0] data_bit(input int idx);
    logic [47:0] bits;
    bits = `DATA_BITS;
    return bits[idx*3 +: 3];
  endfunction : data_bit

  function automatic logic [4:0] cfg_lookup(input logic [7:0] addr);
    logic [127:0] offs;
    logic [4:0]   found;
    offs  = `CFG_OFFS;
    found = 5'h10;
    for (int i = 0; i < 16; i++) begin
      if (addr == offs[i*8 +: 8]) begin
        found = 5'(i);
      end
    end
    return found;
  endfunction : cfg_lookup

  byte_t      cfg [16];
  func_sel_t  func [16];
  pin_vec_t   dataReg, next_data, wakeSt, irqSt;
  pin_vec_t   dir, pol, odSel, dualSel, altSel, inMode;
  pin_vec_t   anyEdge, polEdge, pinEvt, altVal, driveVal, driveOn, dataView;
  pin_vec_t   wakeClr, irqClr;
  logic [3:0] dualWakeSt, miscSt, dualEdge, dualSelV;
  logic       devWakeSt, irSt, wakePinEn;
  byte_t      wakeEn1, wakeEn3, wakeEn5, wakeEn6;
  byte_t      irqEn1, irqEn2, irqEn3, irqEn4;
  byte_t      ledCtl [2];
  byte_t      wakeView1, wakeView3, wakeView5, wakeView6, irqView3, irqView4;
  byte_t      wrData, readMux;
  logic [4:0] cfgFound;
  logic       cfgHit, wakePinSt, groupIrq, groupPinAct, irqLevel, blinkPhase;
  logic       wrW1, wrW3, wrW5, wrW6, wrI3, wrI4, wrMisc, rdIrq2;
  logic [1:0] ledLit;
  logic [BLINK_HALF_BITS:0] blinkCnt;

  pin_edge_if #(.WIDTH(16)) pinEdges ();
  pin_edge_if #(.WIDTH(1))  slowEdges ();

  pin_edge_sync #(.WIDTH(16)) u_pin_sync (
    .mclk  (mclk),
    .reset (reset),
    .rawIn (pinIn),
    .edges (pinEdges)
  );

  pin_edge_sync #(.WIDTH(1)) u_slow_sync (
    .mclk  (mclk),
    .reset (reset),
    .rawIn (clk32k),
    .edges (slowEdges)
  );

  // per-pin configuration fields
  for (genvar i = 0; i < 16; i++) begin : g_pin
    assign dir[i]       = cfg[i][`CFG_DIR_BIT];
    assign pol[i]       = cfg[i][`CFG_POL_BIT];
    assign odSel[i]     = cfg[i][`CFG_OD_BIT];
    assign func[i]      = func_sel_t'(cfg[i][`CFG_FUNC_MSB:`CFG_FUNC_LSB]);
    assign dualSel[i]   = DUAL_PINS[i] && (func[i] == FUNC_DUAL);
    assign altSel[i]    = ALT_PINS[i] && (func[i] == FUNC_ALT);
    assign next_data[i] = (hostWr && data_hit(hostAddr, i) && !inMode[i])
                          ? hostWdata[data_bit(i)] : dataReg[i];
  end

  assign inMode   = dir | dualSel;
  assign anyEdge  = pinEdges.rise | pinEdges.fall;
  assign polEdge  = (pol & pinEdges.fall) | (~pol & pinEdges.rise);
  assign pinEvt   = (dualSel & anyEdge)
                  | (~dualSel & dir & ~altSel & polEdge);
  assign dataView = (inMode & (pinEdges.level ^ pol)) | (~inMode & dataReg);

  // alternate outputs: interrupt, wake request, two active-low leds
  assign irqLevel = pol[`PIN_IRQ_OUT] ? groupPinAct : ~groupPinAct;
  assign altVal   = {~ledLit[1], ~ledLit[0], 8'h00, ~wakeRequest, 2'b00, irqLevel, 2'b00};
  assign driveVal = (altSel & altVal) | (~altSel & (dataReg ^ pol));
  assign driveOn  = ~dualSel & (altSel | ~dir);
  assign pinOut   = driveVal & ~odSel;
  assign pinOe    = driveOn & (~odSel | ~driveVal);

  // status views in register layout
  assign dualEdge  = {anyEdge[15:14], anyEdge[1:0]};
  assign dualSelV  = {dualSel[15:14], dualSel[1:0]};
  assign wakeView1 = {3'h0, dualWakeSt, 1'b0};
  assign wakeView3 = {2'b00, devWakeSt, wakeSt[4:0]};
  assign wakeView5 = wakeSt[13:6];
  assign wakeView6 = {6'h00, wakeSt[15:14]};
  assign irqView3  = {1'b0, irqSt[14:10], irqSt[1:0]};
  assign irqView4  = {4'h0, irqSt[15], irqSt[5:3]};

  assign wakePinSt = |(wakeView1 & wakeEn1 & {3'h0, dualSelV, 1'b0})
                   | |(wakeView3 & wakeEn3) | |(wakeView5 & wakeEn5) | |(wakeView6 & wakeEn6);
  assign wakeRequest = wakePinSt & wakePinEn;

  assign groupIrq = |(periphIrq & irqEn1) | (irSt & irqEn2[`IRQEN2_IR_BIT])
                  | |(irqView3 & irqEn3) | |(irqView4 & irqEn4);
  assign groupIrqInternal = groupIrq;
  assign groupPinAct      = groupIrq & irqEn2[`IRQEN2_PIN_BIT];
  assign serialIrqTwo     = groupIrq & irqEn2[`IRQEN2_SERIAL_BIT];

  // write-one-to-clear strobes and the status-two read-to-clear strobe
  assign wrW1   = hostWr && (hostAddr == `OFF_WAKE_STS1);
  assign wrW3   = hostWr && (hostAddr == `OFF_WAKE_STS3);
  assign wrW5   = hostWr && (hostAddr == `OFF_WAKE_STS5);
  assign wrW6   = hostWr && (hostAddr == `OFF_WAKE_STS6);
  assign wrI3   = hostWr && (hostAddr == `OFF_IRQ_STS3);
  assign wrI4   = hostWr && (hostAddr == `OFF_IRQ_STS4);
  assign wrMisc = hostWr && (hostAddr == `OFF_MISC_STS);
  assign rdIrq2 = hostRd && (hostAddr == `OFF_IRQ_STS2);
  assign wakeClr = {wrW6 ? hostWdata[1:0] : 2'b00, wrW5 ? hostWdata : 8'h00, 1'b0,
                    wrW3 ? hostWdata[4:0] : 5'h00};
  assign irqClr  = {wrI4 & hostWdata[3], wrI3 ? hostWdata[6:2] : 5'h00, 4'h0,
                    wrI4 ? hostWdata[2:0] : 3'h0, 1'b0, wrI3 ? hostWdata[1:0] : 2'b00};
  assign wrData  = hostWr ? hostWdata : 8'h00;

  // sticky statuses: an event in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      wakeSt     <= '0;
      irqSt      <= '0;
      dualWakeSt <= 4'h0;
      miscSt     <= 4'h0;
      devWakeSt  <= 1'b0;
      irSt       <= 1'b0;
    end else begin
      wakeSt     <= (wakeSt & ~wakeClr) | (pinEvt & WAKE_PINS);
      irqSt      <= (irqSt & ~irqClr) | (pinEvt & IRQ_PINS);
      dualWakeSt <= (dualWakeSt & ~(wrW1 ? hostWdata[4:1] : 4'h0)) | dualEdge;
      miscSt     <= (miscSt & ~(wrMisc ? hostWdata[3:0] : 4'h0)) | dualEdge;
      devWakeSt  <= (devWakeSt & ~(wrW3 & hostWdata[`DEV_WAKE_BIT]))
                  | (groupIrq & irqEn2[`IRQEN2_WAKE_BIT]);
      irSt       <= (irSt & ~rdIrq2) | irEvent;
    end
  end

  assign cfgFound = cfg_lookup(hostAddr);
  assign cfgHit   = !cfgFound[4];

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        cfg[i] <= (i == `PIN_IRQ_OUT) ? `CFG_RESET_IRQPIN : `CFG_RESET;
      end
    end else if (hostWr && cfgHit) begin
      cfg[cfgFound[3:0]] <= hostWdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dataReg <= '0;
    end else begin
      dataReg <= next_data;
    end
  end

  // plain read-write control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      wakeEn1   <= `REG_RESET;
      wakeEn3   <= `REG_RESET;
      wakeEn5   <= `REG_RESET;
      wakeEn6   <= `REG_RESET;
      irqEn1    <= `REG_RESET;
      irqEn2    <= `REG_RESET;
      irqEn3    <= `REG_RESET;
      irqEn4    <= `REG_RESET;
      ledCtl[0] <= `REG_RESET;
      ledCtl[1] <= `REG_RESET;
      wakePinEn <= 1'b0;
    end else if (hostWr) begin
      case (hostAddr)
        `OFF_WAKE_EN1:    wakeEn1   <= wrData;
        `OFF_WAKE_EN3:    wakeEn3   <= wrData;
        `OFF_WAKE_EN5:    wakeEn5   <= wrData;
        `OFF_WAKE_EN6:    wakeEn6   <= wrData;
        `OFF_IRQ_EN1:     irqEn1    <= wrData;
        `OFF_IRQ_EN2:     irqEn2    <= wrData;
        `OFF_IRQ_EN3:     irqEn3    <= wrData;
        `OFF_IRQ_EN4:     irqEn4    <= wrData;
        `OFF_LED_ONE:     ledCtl[0] <= wrData;
        `OFF_LED_TWO:     ledCtl[1] <= wrData;
        `OFF_WAKE_PIN_EN: wakePinEn <= wrData[0];
        default:          ;
      endcase
    end
  end

  // blink phase advances only on slow clock edges, so a missing clock freezes it
  always_ff @(posedge mclk) begin
    if (reset) begin
      blinkCnt <= '0;
    end else if (slowEdges.rise[0]) begin
      blinkCnt <= blinkCnt + 1'b1;
    end
  end

  assign blinkPhase = blinkCnt[BLINK_HALF_BITS];
  for (genvar k = 0; k < 2; k++) begin : g_led
    assign ledLit[k] = (led_mode_t'(ledCtl[k][1:0]) == LED_ON)
                     || ((led_mode_t'(ledCtl[k][1:0]) == LED_BLINK) && blinkPhase);
  end

  always_comb begin
    readMux = 8'h00;
    if (cfgHit) begin
      readMux = cfg[cfgFound[3:0]];
    end
    for (int i = 0; i < 16; i++) begin
      if (data_hit(hostAddr, i)) begin
        readMux[data_bit(i)] = dataView[i];
      end
    end
    case (hostAddr)
      `OFF_WAKE_PIN_STS: readMux = {7'h00, wakePinSt};
      `OFF_WAKE_PIN_EN:  readMux = {7'h00, wakePinEn};
      `OFF_WAKE_STS1:    readMux = wakeView1;
      `OFF_WAKE_STS3:    readMux = wakeView3;
      `OFF_WAKE_STS5:    readMux = wakeView5;
      `OFF_WAKE_STS6:    readMux = wakeView6;
      `OFF_WAKE_EN1:     readMux = wakeEn1;
      `OFF_WAKE_EN3:     readMux = wakeEn3;
      `OFF_WAKE_EN5:     readMux = wakeEn5;
      `OFF_WAKE_EN6:     readMux = wakeEn6;
      `OFF_IRQ_STS1:     readMux = periphIrq;
      `OFF_IRQ_STS2:     readMux = {7'h00, irSt};
      `OFF_IRQ_STS3:     readMux = irqView3;
      `OFF_IRQ_STS4:     readMux = irqView4;
      `OFF_IRQ_EN1:      readMux = irqEn1;
      `OFF_IRQ_EN2:      readMux = irqEn2;
      `OFF_IRQ_EN3:      readMux = irqEn3;
      `OFF_IRQ_EN4:      readMux = irqEn4;
      `OFF_MISC_STS:     readMux = {4'h0, miscSt};
      `OFF_LED_ONE:      readMux = ledCtl[0];
      `OFF_LED_TWO:      readMux = ledCtl[1];
      default:           ;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hostRdata <= 8'h00;
    end else if (hostRd) begin
      hostRdata <= readMux;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_pin6_rises;
    dir[6] && !pol[6] && pinEdges.rise[6];
  endsequence
  sequence s_out_write;
    hostWr && hostAddr == `OFF_DATA5 && !dir[6];
  endsequence
  sequence s_misc_clear;
    hostWr && hostAddr == `OFF_MISC_STS && hostWdata[0];
  endsequence

  a_rise_sets_wake: assert property (s_pin6_rises
    |=> wakeSt[6] ##1 (wakeSt[6] || $past(wakeClr[6])))
    else $error("input rising edge did not leave wake status set");
  a_output_no_event: assert property ((!dir[6] && !wakeSt[6]) |=> !wakeSt[6])
    else $error("output pin raised a wake status");
  a_input_read_level: assert property ((hostRd && hostAddr == `OFF_DATA5 && dir[6])
    |=> hostRdata[0] == ($past(pinEdges.level[6]) ^ $past(pol[6])))
    else $error("input read did not return pin level with polarity");
  a_input_write_kept: assert property ((hostWr && hostAddr == `OFF_DATA5 && dir[6])
    |=> $stable(dataReg[6]))
    else $error("write to input pin changed its data");
  a_output_drive: assert property (s_out_write
    |=> (pinOe[6] ? pinOut[6] : 1'b1) == ($past(hostWdata[0]) ^ pol[6]))
    else $error("output pin level does not follow written data");
  a_dual_both_edges: assert property ((dualSel[0] && pinEdges.fall[0])
    |=> wakeSt[0] && irqSt[0])
    else $error("either-edge pin missed a falling edge");
  a_misc_any_edge: assert property (anyEdge[14] |=> miscSt[2] && dualWakeSt[2])
    else $error("either-edge status missed a transition");
  a_misc_clear: assert property ((s_misc_clear and !dualEdge[0]) |=> !miscSt[0])
    else $error("write one did not clear misc status");
  a_clear_set_wins: assert property ((s_misc_clear and dualEdge[0]) |=> miscSt[0])
    else $error("edge lost in the clearing cycle");
  a_ir_read_clear: assert property ((irSt && rdIrq2 && !irEvent) |=> !irSt)
    else $error("infrared status survived a status two read");
  a_dev_wake: assert property ((groupIrq && irqEn2[`IRQEN2_WAKE_BIT]) |=> devWakeSt)
    else $error("group interrupt not routed into wake status");
  a_serial_gate: assert property ((irSt && irqEn2[`IRQEN2_IR_BIT]
    && irqEn2[`IRQEN2_SERIAL_BIT]) |-> serialIrqTwo)
    else $error("enabled source missing from serial interrupt two");
  a_irq_pin_low: assert property ((altSel[`PIN_IRQ_OUT] && !pol[`PIN_IRQ_OUT]
    && irSt && irqEn2[`IRQEN2_IR_BIT] && irqEn2[`IRQEN2_PIN_BIT])
    |-> pinOe[`PIN_IRQ_OUT] && !pinOut[`PIN_IRQ_OUT])
    else $error("active-low interrupt pin not driven low");
endmodule : gpio_wake_smi_event_logic

//--- testbench/pin_world.sv
/*
  Pad model for the sixteen pins: block drive wins, else the outside driver, else pull-up.
  Assumes pinOe high means the block drives the pad.
*/
`timescale 1ns/1ns
module pin_world (
  input  wire logic [15:0] pinOut,
  input  wire logic [15:0] pinOe,
  input  wire logic [15:0] extDrive,
  input  wire logic [15:0] extEn,
  output logic      [15:0] padLevel
);
  // a pad released by both the block and the outside driver floats up, as an open-drain line with a pull-up would
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      padLevel[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extDrive[i] : 1'b1);
    end
  end
endmodule : pin_world

//--- testbench/gpio_wake_smi_event_logic_tb.sv
/*
  Self-checking bench for the gpio wake block: host register calls with expected values.
  Assumes pin_world and the design files are compiled first.
*/
`timescale 1ns/1ns
module gpio_wake_smi_event_logic_tb;
  import gpio_wake_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  hostAddr = 8'h00;
  logic        hostWr = 1'b0;
  logic        hostRd = 1'b0;
  byte_t       hostWdata = 8'h00;
  byte_t       hostRdata;
  byte_t       periphIrq = 8'h00;
  pin_vec_t    pinIn;
  pin_vec_t    pinOut;
  pin_vec_t    pinOe;
  logic [15:0] extDrive = 16'h0000;
  logic        clk32k = 1'b0;
  logic        irEvent = 1'b0;
  logic        groupIrq;
  logic        serialIrq;
  logic        wakeReq;
  int          errCount = 0;
  int          numChecks = 0;
  int          cycles = 0;

  always #2 mclk = ~mclk;

  gpio_wake_smi_event_logic #(.BLINK_HALF_BITS(2)) i_gpio_wake_smi_event_logic (
    .mclk(mclk), .reset(reset), .hostAddr(hostAddr), .hostWr(hostWr), .hostRd(hostRd),
    .hostWdata(hostWdata), .hostRdata(hostRdata), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .clk32k(clk32k), .periphIrq(periphIrq), .irEvent(irEvent),
    .groupIrqInternal(groupIrq), .serialIrqTwo(serialIrq), .wakeRequest(wakeReq));
  pin_world i_pin_world (.pinOut(pinOut), .pinOe(pinOe), .extDrive(extDrive),
    .extEn(16'hFFFF), .padLevel(pinIn));

  task automatic report_and_stop;
    $display("checks %0d errors %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input byte_t exp, input byte_t got);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input byte_t addr, input byte_t data);
    @(negedge mclk);
    hostAddr = addr;
    hostWdata = data;
    hostWr = 1'b1;
    @(negedge mclk);
    hostWr = 1'b0;
  endtask : wr

  task automatic rd(input byte_t addr, input byte_t mask, input byte_t exp, input string what);
    @(negedge mclk);
    hostAddr = addr;
    hostRd = 1'b1;
    @(negedge mclk);
    hostRd = 1'b0;
    check(what, exp & mask, hostRdata & mask);
  endtask : rd

  // status lands three edges after the pad moves; four leaves margin
  task automatic pin(input int idx, input logic v);
    @(negedge mclk);
    extDrive[idx] = v;
    repeat (4) @(negedge mclk);
  endtask : pin

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      report_and_stop();
    end
  end

  initial begin
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    rd(8'h3F, 8'hFF, 8'h01, "cfg pin6 reset");
    rd(8'h32, 8'hFF, 8'h81, "cfg irq pin reset");
    check("oe reset", 8'h00, pinOe[7:0]);
    pin(6, 1'b1);
    wr(8'h4F, 8'h00);
    rd(8'h4F, 8'h01, 8'h01, "input level");
    rd(8'h14, 8'h01, 8'h01, "wake five rise");
    wr(8'h3F, 8'h03);
    rd(8'h4F, 8'h01, 8'h00, "inverted input");
    wr(8'h14, 8'h01);
    rd(8'h14, 8'h01, 8'h00, "wake five clear");
    pin(6, 1'b0);
    rd(8'h14, 8'h01, 8'h01, "wake five fall");
    wr(8'h18, 8'h01);
    wr(8'h11, 8'h01);
    check("wake out set", 8'h01, {7'h00, wakeReq});
    wr(8'h14, 8'h01);
    wr(8'h3F, 8'h00);
    wr(8'h4F, 8'h01);
    check("out drive", 8'h03, {6'h00, pinOe[6], pinOut[6]});
    rd(8'h4F, 8'h01, 8'h01, "out readback");
    wr(8'h3F, 8'h02);
    check("out inverted", 8'h02, {6'h00, pinOe[6], pinOut[6]});
    wr(8'h3F, 8'h80);
    check("od release", 8'h00, {7'h00, pinOe[6]});
    wr(8'h4F, 8'h00);
    check("od low", 8'h02, {6'h00, pinOe[6], pinOut[6]});
    wr(8'h3F, 8'h01);
    rd(8'h14, 8'h01, 8'h00, "output no event");
    check("wake out clear", 8'h00, {7'h00, wakeReq});
    pin(10, 1'b1);
    rd(8'h1C, 8'h04, 8'h04, "irq three pin10");
    check("group masked", 8'h00, {7'h00, groupIrq});
    wr(8'h20, 8'h04);
    check("group set", 8'h01, {7'h00, groupIrq});
    check("serial off", 8'h00, {7'h00, serialIrq});
    wr(8'h1F, 8'h40);
    check("serial on", 8'h01, {7'h00, serialIrq});
    wr(8'h1C, 8'h04);
    check("group clear", 8'h00, {7'h00, groupIrq});
    pin(0, 1'b1);
    rd(8'h22, 8'h01, 8'h01, "misc rise");
    wr(8'h22, 8'h01);
    rd(8'h22, 8'h01, 8'h00, "misc clear");
    pin(0, 1'b0);
    rd(8'h22, 8'h01, 8'h01, "misc fall unselected");
    periphIrq = 8'h01;
    wr(8'h1A, 8'hFF);
    rd(8'h1A, 8'h01, 8'h01, "periph live");
    periphIrq = 8'h00;
    rd(8'h1A, 8'h01, 8'h00, "periph source clear");
    // pin0 in either-edge mode: direction bit says output, yet the pad stays released
    wr(8'h13, 8'h01);
    wr(8'h2C, 8'h08);
    check("dual no drive", 8'h00, {7'h00, pinOe[0]});
    pin(0, 1'b1);
    rd(8'h13, 8'h01, 8'h01, "dual rise");
    wr(8'h13, 8'h01);
    pin(0, 1'b0);
    rd(8'h13, 8'h01, 8'h01, "dual fall");
    check("dual wake off", 8'h00, {7'h00, wakeReq});
    wr(8'h16, 8'h02);
    rd(8'h10, 8'h01, 8'h01, "dual wake on");
    wr(8'h2C, 8'h01);
    rd(8'h10, 8'h01, 8'h00, "dual wake unselected");
    irEvent = 1'b1;
    @(negedge mclk);
    irEvent = 1'b0;
    wr(8'h32, 8'h85);
    check("irq pin idle", 8'h00, {7'h00, pinOe[2]});
    wr(8'h1F, 8'hE1);
    check("irq pin low", 8'h02, {6'h00, pinOe[2], pinOut[2]});
    check("group ir", 8'h01, {7'h00, groupIrq});
    rd(8'h13, 8'h20, 8'h20, "device wake");
    rd(8'h1B, 8'h01, 8'h01, "ir sticky");
    rd(8'h1B, 8'h01, 8'h00, "ir read clear");
    check("irq pin off", 8'h00, {7'h00, pinOe[2]});
    wr(8'h47, 8'h04);
    wr(8'h5D, 8'h01);
    check("led on", 8'h02, {6'h00, pinOe[14], pinOut[14]});
    wr(8'h5D, 8'h02);
    check("blink no clock", 8'h03, {6'h00, pinOe[14], pinOut[14]});
    // four slow rises move the shortened blink counter into its lit half
    repeat (4) begin
      clk32k = 1'b1;
      repeat (3) @(negedge mclk);
      clk32k = 1'b0;
      repeat (3) @(negedge mclk);
    end
    check("blink lit", 8'h02, {6'h00, pinOe[14], pinOut[14]});
    report_and_stop();
  end
endmodule : gpio_wake_smi_event_logic_tb
